// ===== hdl/inertial_spi_port.v
// Function
// - Serial mode 3: clock idles high, data captured on rising edge.
// - Frames are 16 bits, most significant bit first, both directions.
// - Device changes its serial output on falling clock edges.
// - Device captures its serial input on rising clock edges.
// - After a read request, whole addressed word shifts out next frame.
// - Full duplex: next command travels while previous answer shifts out.
// - Top bit 1 writes low byte into addressed byte at frame end.
// - Each word has separate upper and lower byte addresses.
// - Command word 0xBE04 starts flash backup taking 50 ms.
// - Flash write counter increments on each backup and is readable.
// - Sampling starts by itself after reset at 819.2 SPS.
// - Each sample cycle loads results, then pulses data-ready high.
// - Fourth pin is general I/O or external sync clock input.
// - Upper byte address equals lower byte address plus one.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "inertial_spi_defs.vh"

module inertial_spi_port #(
  parameter integer FLASH_CYCLES  = `FLASH_TIME_MS * (`CLK_HZ / 1000),
  parameter integer SAMPLE_CYCLES = (`CLK_HZ * 10) / `SAMPLE_RATE_DSPS
) (
  input  wire                        ref_clk_i,
  input  wire                        rstn_i,
  input  wire                        spi_clk_i,
  input  wire                        spi_cs_n_i,
  input  wire                        spi_mosi_i,
  output reg                         spi_miso_o,
  output reg                         data_ready_pin_o,
  input  wire                        sync_clock_or_gpio_pin_i,
  output reg                         sync_clock_or_gpio_pin_o,
  output reg                         sync_clock_or_gpio_pin_oe_n_o,
  input  wire [16*`NUM_RESULTS-1:0]  result_data_i,
  output reg                         flash_busy_o,
  output reg                         irq_o,
  input  wire                        s_axi_awvalid,
  output reg                         s_axi_awready,
  input  wire [3:0]                  s_axi_awaddr,
  input  wire                        s_axi_wvalid,
  output reg                         s_axi_wready,
  input  wire [31:0]                 s_axi_wdata,
  input  wire [3:0]                  s_axi_wstrb,
  output reg                         s_axi_bvalid,
  input  wire                        s_axi_bready,
  output reg  [1:0]                  s_axi_bresp,
  input  wire                        s_axi_arvalid,
  output reg                         s_axi_arready,
  input  wire [3:0]                  s_axi_araddr,
  output reg                         s_axi_rvalid,
  input  wire                        s_axi_rready,
  output reg  [31:0]                 s_axi_rdata,
  output reg  [1:0]                  s_axi_rresp
);

  localparam ST_INIT  = 2'd0;
  localparam ST_IDLE  = 2'd1;
  localparam ST_LOAD  = 2'd2;
  localparam ST_PULSE = 2'd3;
  localparam [15:0] PERIOD_RESET = `RST_SAMPLE_PERIOD;

  function is_writable;
    input [6:0] a;
    begin
      is_writable = (a >= `ADDR_WR_FIRST) && (a <= `ADDR_WR_LAST);
    end
  endfunction

  function [15:0] reset_word;
    input [5:0] idx;
    begin
      case (idx)
        `WORD_MISC_CONTROL:   reset_word = `RST_MISC_CONTROL;
        `WORD_SAMPLE_PERIOD:  reset_word = `RST_SAMPLE_PERIOD;
        `WORD_FILTER_CONTROL: reset_word = `RST_FILTER_CONTROL;
        default:              reset_word = 16'h0000;
      endcase
    end
  endfunction

  // Pin synchronisers: first stage feeds only the second
  reg        sclk_m_reg, sclk_s_reg, sclk_d_reg;
  reg        cs_m_reg, cs_s_reg;
  reg        mosi_m_reg, mosi_s_reg;
  reg        sync_m_reg, sync_s_reg, sync_d_reg;

  reg [4:0]  bit_cnt_reg;
  reg [15:0] rx_sh_reg;
  reg [15:0] tx_sh_reg;
  reg [15:0] tx_word_reg;
  reg [15:0] frame_word_reg;
  reg        frame_done_reg;
  reg        rd_pend_reg;
  reg        spi_wr_pend_reg;
  reg [6:0]  spi_wr_addr_reg;
  reg [7:0]  spi_wr_data_reg;
  reg [7:0]  sample_period_reg;
  reg [15:0] flash_count_reg;
  reg [19:0] flash_tmr_reg;
  reg [1:0]  state_reg;
  reg [5:0]  init_idx_reg;
  reg [3:0]  load_idx_reg;
  reg [23:0] smp_cnt_reg;
  reg [4:0]  pulse_cnt_reg;
  reg [2:0]  status_reg;
  reg [2:0]  mask_reg;
  reg [2:0]  ctrl_reg;
  reg        sample_ev;
  reg        flash_ev;

  wire        sclk_rise = sclk_s_reg & ~sclk_d_reg;
  wire        sclk_fall = ~sclk_s_reg & sclk_d_reg;
  wire        sync_rise = sync_s_reg & ~sync_d_reg;
  wire [15:0] mem_rdata;
  wire [7:0]  eff_prd   = (sample_period_reg == 8'h00) ? 8'h01 : sample_period_reg;
  wire [31:0] smp_limit = SAMPLE_CYCLES * {24'h00_0000, eff_prd};
  wire        timer_hit = ({8'h00, smp_cnt_reg} >= smp_limit - 32'h0000_0001);
  wire        loader_we = ((state_reg == ST_INIT) || (state_reg == ST_LOAD)) && !spi_wr_pend_reg;
  wire [15:0] result_word = result_data_i[load_idx_reg*16 +: 16];
  wire [6:0]  result_waddr = (`ADDR_RESULT_FIRST >> 1) + {3'b000, load_idx_reg};

  reg         mem_we;
  reg  [1:0]  mem_be;
  reg  [5:0]  mem_waddr;
  reg  [15:0] mem_wdata;

  // Host byte writes win the write port; the loader waits one cycle
  always @* begin
    mem_we    = 1'b0;
    mem_be    = 2'b00;
    mem_waddr = 6'h00;
    mem_wdata = 16'h0000;
    if (spi_wr_pend_reg) begin
      mem_we    = 1'b1;
      mem_be    = spi_wr_addr_reg[0] ? 2'b10 : 2'b01;
      mem_waddr = spi_wr_addr_reg[6:1];
      mem_wdata = {spi_wr_data_reg, spi_wr_data_reg};
    end else if (loader_we) begin
      mem_we    = 1'b1;
      mem_be    = 2'b11;
      if (state_reg == ST_INIT) begin
        mem_waddr = init_idx_reg;
        mem_wdata = reset_word(init_idx_reg);
      end else begin
        mem_waddr = result_waddr[5:0];
        mem_wdata = result_word;
      end
    end
  end

  user_reg_mem #(
    .AW (6),
    .DW (16)
  ) u_mem (
    .ref_clk_i (ref_clk_i),
    .we_i      (mem_we),
    .be_i      (mem_be),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .raddr_i   (frame_word_reg[`FRM_WORD_HI:`FRM_WORD_LO]),
    .rdata_o   (mem_rdata)
  );

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_m_reg <= 1'b1;
      sclk_s_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
      cs_m_reg   <= 1'b1;
      cs_s_reg   <= 1'b1;
      mosi_m_reg <= 1'b0;
      mosi_s_reg <= 1'b0;
      sync_m_reg <= 1'b0;
      sync_s_reg <= 1'b0;
      sync_d_reg <= 1'b0;
    end else begin
      sclk_m_reg <= spi_clk_i;
      sclk_s_reg <= sclk_m_reg;
      sclk_d_reg <= sclk_s_reg;
      cs_m_reg   <= spi_cs_n_i;
      cs_s_reg   <= cs_m_reg;
      mosi_m_reg <= spi_mosi_i;
      mosi_s_reg <= mosi_m_reg;
      sync_m_reg <= sync_clock_or_gpio_pin_i;
      sync_s_reg <= sync_m_reg;
      sync_d_reg <= sync_s_reg;
    end
  end

  // Serial shifter; idle-high clock so the first edge seen is a fall
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_reg    <= 5'd0;
      rx_sh_reg      <= 16'h0000;
      tx_sh_reg      <= 16'h0000;
      spi_miso_o     <= 1'b0;
      frame_word_reg <= 16'h0000;
      frame_done_reg <= 1'b0;
    end else begin
      frame_done_reg <= 1'b0;
      if (cs_s_reg) begin
        bit_cnt_reg <= 5'd0;
        tx_sh_reg   <= tx_word_reg;
      end else if (bit_cnt_reg < `FRAME_BITS) begin
        if (sclk_fall) begin
          spi_miso_o <= tx_sh_reg[15];
          tx_sh_reg  <= {tx_sh_reg[14:0], 1'b0};
        end
        if (sclk_rise) begin
          rx_sh_reg   <= {rx_sh_reg[14:0], mosi_s_reg};
          bit_cnt_reg <= bit_cnt_reg + 5'd1;
          if (bit_cnt_reg == `FRAME_BITS - 1) begin
            frame_word_reg <= {rx_sh_reg[14:0], mosi_s_reg};
            frame_done_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Command decode; answer is ready two cycles after the frame ends
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_word_reg     <= 16'h0000;
      rd_pend_reg     <= 1'b0;
      spi_wr_pend_reg <= 1'b0;
      spi_wr_addr_reg <= 7'h00;
      spi_wr_data_reg <= 8'h00;
      sample_period_reg <= PERIOD_RESET[7:0];
      flash_count_reg <= 16'h0000;
      flash_tmr_reg   <= 20'd0;
      flash_busy_o    <= 1'b0;
      flash_ev        <= 1'b0;
    end else begin
      rd_pend_reg     <= 1'b0;
      spi_wr_pend_reg <= 1'b0;
      flash_ev        <= 1'b0;
      if (frame_done_reg) begin
        if (frame_word_reg[`FRM_WRITE_BIT]) begin
          tx_word_reg     <= 16'h0000;
          spi_wr_addr_reg <= frame_word_reg[`FRM_ADDR_HI:`FRM_ADDR_LO];
          spi_wr_data_reg <= frame_word_reg[7:0];
          spi_wr_pend_reg <= is_writable(frame_word_reg[`FRM_ADDR_HI:`FRM_ADDR_LO]);
          if (frame_word_reg[`FRM_ADDR_HI:`FRM_ADDR_LO] == `ADDR_SAMPLE_PERIOD) begin
            sample_period_reg <= frame_word_reg[7:0];
          end
          if ((frame_word_reg[`FRM_ADDR_HI:`FRM_ADDR_LO] == `ADDR_GLOBAL_CMD) &&
              frame_word_reg[`GLOB_FLASH_BIT] && !flash_busy_o) begin
            flash_busy_o  <= 1'b1;
            flash_tmr_reg <= 20'd0;
          end
        end else begin
          rd_pend_reg <= 1'b1;
        end
      end
      if (rd_pend_reg) begin
        // Counter lives outside the memory so a backup never races a host write
        if (frame_word_reg[`FRM_WORD_HI:`FRM_WORD_LO] == `ADDR_FLASH_COUNT / 2) begin
          tx_word_reg <= flash_count_reg;
        end else begin
          tx_word_reg <= mem_rdata;
        end
      end
      if (flash_busy_o) begin
        if (flash_tmr_reg == FLASH_CYCLES - 1) begin
          flash_busy_o  <= 1'b0;
          flash_count_reg <= flash_count_reg + 16'h0001;
          flash_ev      <= 1'b1;
        end else begin
          flash_tmr_reg <= flash_tmr_reg + 20'd1;
        end
      end
    end
  end

  // Autonomous sampling: defaults, then timer or sync pin paced loads
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg        <= ST_INIT;
      init_idx_reg     <= 6'h00;
      load_idx_reg     <= 4'h0;
      smp_cnt_reg      <= 24'h00_0000;
      pulse_cnt_reg    <= 5'd0;
      data_ready_pin_o <= 1'b0;
      sample_ev        <= 1'b0;
    end else begin
      sample_ev <= 1'b0;
      if (ctrl_reg[`CTRL_SYNC_MODE] || timer_hit) begin
        smp_cnt_reg <= 24'h00_0000;
      end else begin
        smp_cnt_reg <= smp_cnt_reg + 24'h00_0001;
      end
      case (state_reg)
        ST_INIT: begin
          if (loader_we) begin
            init_idx_reg <= init_idx_reg + 6'h01;
            if (init_idx_reg == 6'h3F) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          if (ctrl_reg[`CTRL_SYNC_MODE] ? sync_rise : timer_hit) begin
            load_idx_reg <= 4'h0;
            state_reg    <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (loader_we) begin
            load_idx_reg <= load_idx_reg + 4'h1;
            if (load_idx_reg == `NUM_RESULTS - 1) begin
              state_reg        <= ST_PULSE;
              data_ready_pin_o <= 1'b1;
              pulse_cnt_reg    <= 5'd0;
              sample_ev        <= 1'b1;
            end
          end
        end
        ST_PULSE: begin
          pulse_cnt_reg <= pulse_cnt_reg + 5'd1;
          if (pulse_cnt_reg == `DRDY_PULSE_CYCLES - 1) begin
            data_ready_pin_o <= 1'b0;
            state_reg        <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Register bus slave, one write and one read at a time
  wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire [2:0] events = {flash_ev, sample_ev, frame_done_reg};

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_awready                 <= 1'b0;
      s_axi_wready                  <= 1'b0;
      s_axi_bvalid                  <= 1'b0;
      s_axi_bresp                   <= `AXI_RESP_OKAY;
      s_axi_arready                 <= 1'b0;
      s_axi_rvalid                  <= 1'b0;
      s_axi_rdata                   <= 32'h0000_0000;
      s_axi_rresp                   <= `AXI_RESP_OKAY;
      status_reg                    <= 3'b000;
      mask_reg                      <= 3'b000;
      ctrl_reg                      <= 3'b000;
      irq_o                         <= 1'b0;
      sync_clock_or_gpio_pin_o      <= 1'b0;
      sync_clock_or_gpio_pin_oe_n_o <= 1'b1;
    end else begin
      s_axi_awready <= aw_take;
      s_axi_wready  <= aw_take;
      s_axi_arready <= ar_take;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Set wins over a same-cycle write-one clear
      status_reg <= status_reg | events;
      if (aw_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `AXI_RESP_OKAY;
        case (s_axi_awaddr)
          `AXI_STATUS: begin
            if (s_axi_wstrb[0]) begin
              status_reg <= (status_reg & ~s_axi_wdata[2:0]) | events;
            end
          end
          `AXI_MASK: begin
            if (s_axi_wstrb[0]) begin
              mask_reg <= s_axi_wdata[2:0];
            end
          end
          `AXI_CTRL: begin
            if (s_axi_wstrb[0]) begin
              ctrl_reg <= s_axi_wdata[2:0];
            end
          end
          `AXI_STATE: s_axi_bresp <= `AXI_RESP_OKAY;
          default:    s_axi_bresp <= `AXI_RESP_DECERR;
        endcase
      end
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `AXI_RESP_OKAY;
        case (s_axi_araddr)
          `AXI_STATUS: s_axi_rdata <= {29'h0, status_reg};
          `AXI_MASK:   s_axi_rdata <= {29'h0, mask_reg};
          `AXI_CTRL:   s_axi_rdata <= {29'h0, ctrl_reg};
          `AXI_STATE:  s_axi_rdata <= {14'h0, sync_s_reg, flash_busy_o, flash_count_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_RESP_DECERR;
          end
        endcase
      end
      irq_o <= |(status_reg & mask_reg);
      // Pin is an input whenever it paces sampling
      sync_clock_or_gpio_pin_o      <= ctrl_reg[`CTRL_GPIO_OUT];
      sync_clock_or_gpio_pin_oe_n_o <= ctrl_reg[`CTRL_SYNC_MODE] | ~ctrl_reg[`CTRL_GPIO_DIR];
    end
  end

endmodule

`default_nettype wire

// ===== hdl/inertial_spi_defs.vh
`ifndef INERTIAL_SPI_DEFS_VH
`define INERTIAL_SPI_DEFS_VH

// Timing
`define CLK_HZ             20000000
`define FLASH_TIME_MS      50
`define SAMPLE_RATE_DSPS   8192
`define DRDY_PULSE_CYCLES  16

// Serial frame layout
`define FRAME_BITS         16
`define FRM_WRITE_BIT      15
`define FRM_ADDR_HI        14
`define FRM_ADDR_LO        8
`define FRM_WORD_HI        14
`define FRM_WORD_LO        9

// Device register byte addresses (lower byte; ADDR_WR_LAST is an upper byte)
`define ADDR_FLASH_COUNT   7'h00
`define ADDR_RESULT_FIRST  7'h02
`define ADDR_WR_FIRST      7'h1A
`define ADDR_WR_LAST       7'h3B
`define ADDR_SAMPLE_PERIOD 7'h36
`define ADDR_GLOBAL_CMD    7'h3E
`define GLOB_FLASH_BIT     2

// Device register reset values
`define WORD_MISC_CONTROL   6'h1A
`define WORD_SAMPLE_PERIOD  6'h1B
`define WORD_FILTER_CONTROL 6'h1C
`define RST_MISC_CONTROL    16'h0006
`define RST_SAMPLE_PERIOD   16'h0001
`define RST_FILTER_CONTROL  16'h0402
`define NUM_RESULTS        11

// Bus register offsets
`define AXI_STATUS         4'h0
`define AXI_MASK           4'h4
`define AXI_CTRL           4'h8
`define AXI_STATE          4'hC
`define AXI_RESP_OKAY      2'b00
`define AXI_RESP_DECERR    2'b11

// Event bits
`define EV_FRAME           0
`define EV_SAMPLE          1
`define EV_FLASH           2

// Control bits
`define CTRL_SYNC_MODE     0
`define CTRL_GPIO_DIR      1
`define CTRL_GPIO_OUT      2

`endif

// ===== hdl/user_reg_mem.v
`timescale 1ns/1ps
`default_nettype none

module user_reg_mem #(
  parameter AW = 6,
  parameter DW = 16
) (
  input  wire          ref_clk_i,
  input  wire          we_i,
  input  wire [1:0]    be_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Read before write on the same word
  always @(posedge ref_clk_i) begin
    rdata_o <= mem[raddr_i];
    if (we_i && be_i[0]) begin
      mem[waddr_i][DW/2-1:0] <= wdata_i[DW/2-1:0];
    end
    if (we_i && be_i[1]) begin
      mem[waddr_i][DW-1:DW/2] <= wdata_i[DW-1:DW/2];
    end
  end

endmodule

`default_nettype wire

// ===== tb/inertial_spi_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module inertial_spi_port_props #(
  parameter integer FLASH_CYCLES = 50
) (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic        spi_clk_i,
  input wire logic        spi_cs_n_i,
  input wire logic        spi_miso_o,
  input wire logic        data_ready_pin_o,
  input wire logic        flash_busy_o,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0]  dr_cnt;
  logic [31:0] fl_cnt;
  // Run lengths of the two pulse outputs
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dr_cnt <= 8'h00;
      fl_cnt <= 32'h0000_0000;
    end else begin
      dr_cnt <= data_ready_pin_o ? dr_cnt + 8'h01 : 8'h00;
      fl_cnt <= flash_busy_o ? fl_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  // Output moves only shortly after a falling serial clock
  a_miso_after_fall: assert property ($changed(spi_miso_o) && !spi_cs_n_i |->
    !$past(spi_clk_i) || !$past(spi_clk_i, 2) || !$past(spi_clk_i, 3) || !$past(spi_clk_i, 4))
    else $error("serial output changed away from a falling clock");
  a_miso_idle_hold: assert property (spi_cs_n_i [*4] |-> $stable(spi_miso_o))
    else $error("serial output moved while deselected");
  a_ready_pulse_len: assert property ($fell(data_ready_pin_o) |-> dr_cnt == 8'h10)
    else $error("data ready pulse width wrong");
  a_flash_busy_len: assert property ($fell(flash_busy_o) |-> fl_cnt == FLASH_CYCLES)
    else $error("flash backup duration wrong");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_awready_single: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write ready held too long");
  c_ready_seen: cover property ($rose(data_ready_pin_o));
  c_flash_done: cover property ($fell(flash_busy_o));
  c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
  c_rd_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind inertial_spi_port inertial_spi_port_props #(.FLASH_CYCLES(FLASH_CYCLES)) u_props (.ref_clk_i, .rstn_i,
  .spi_clk_i, .spi_cs_n_i, .spi_miso_o, .data_ready_pin_o, .flash_busy_o, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ===== tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic     sclk_o,
  output logic     cs_n_o,
  output logic     mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Low phase longer than high so the synced output settles before capture
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    cs_n_o = 1'b0;
    #200;
    for (i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = tx[i];
      #240;
      rx[i] = miso_i;
      sclk_o = 1'b1;
      #160;
    end
    #100;
    cs_n_o = 1'b1;
    mosi_o = ~tx[0];
    #300;
  endtask
  // Clock pulses while deselected
  task automatic noise(input logic [7:0] pat);
    int i;
    for (i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = pat[i];
      #200;
      sclk_o = 1'b1;
      #200;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_inertial_spi_register_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_inertial_spi_register_port;
  logic         ref_clk_i = 1'b0;
  logic         rstn_i = 1'b0;
  wire          sclk, cs_n, mosi, miso, dr, pin_o, oe_n, busy, irq;
  logic         pin_drv = 1'b0;
  logic [175:0] res = '0;
  logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]   awaddr = 4'h0, araddr = 4'h0;
  logic [31:0]  wdata = 32'h0000_0000;
  wire          awready, wready, bvalid, arready, rvalid;
  wire [1:0]    bresp, rresp;
  wire [31:0]   rdata;
  wire          pin_lvl = oe_n ? pin_drv : pin_o;
  int           err_total = 0, compares = 0, cyc = 0;
  logic [15:0]  mem [64];
  logic [15:0]  prev_ans;
  logic [31:0]  rd;
  logic [6:0]   wa;
  bit           first = 1, hit;
  inertial_spi_port #(.FLASH_CYCLES(50), .SAMPLE_CYCLES(200)) DUT (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .spi_clk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .data_ready_pin_o(dr), .sync_clock_or_gpio_pin_i(pin_lvl),
    .sync_clock_or_gpio_pin_o(pin_o), .sync_clock_or_gpio_pin_oe_n_o(oe_n), .result_data_i(res),
    .flash_busy_o(busy), .irq_o(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  spi_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One frame; the answer seen belongs to the frame before
  task automatic frame(input logic [15:0] cmd);
    logic [15:0] r;
    logic [6:0]  a;
    u_host.xfer(cmd, r);
    if (!first) chk("serial answer", r, prev_ans);
    first = 0;
    a = cmd[14:8];
    if (cmd[15]) begin
      if (a >= 7'h1a && a <= 7'h3b) begin
        if (a[0]) mem[a[6:1]][15:8] = cmd[7:0];
        else mem[a[6:1]][7:0] = cmd[7:0];
      end
      prev_ans = 16'h0000;
    end else prev_ans = mem[a[6:1]];
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, (a[1:0] == 2'b00) ? 2'b00 : 2'b11);
    @(posedge ref_clk_i);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", rresp, (a[1:0] == 2'b00) ? 2'b00 : 2'b11);
    @(posedge ref_clk_i);
  endtask
  task automatic wait_dr(input int lim, output bit found);
    logic last;
    int   n;
    found = 0;
    last = dr;
    for (n = 0; n < lim && !found; n++) begin
      @(posedge ref_clk_i);
      found = (dr === 1'b1 && last !== 1'b1);
      last = dr;
    end
  endtask
  initial begin
    void'($urandom(32'hfcab_de96));
    for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
    for (int k = 0; k < 11; k++) begin
      res[16*k +: 16] = 16'($urandom);
      mem[k+1] = res[16*k +: 16];
    end
    mem[26] = 16'h0006;
    mem[27] = 16'h0001;
    mem[28] = 16'h0402;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    wait_dr(800, hit);
    chk("ready after reset", 32'(hit), 1);
    for (int k = 0; k < 11; k++) frame({1'b0, 7'(2*k+2), 8'($urandom)});
    frame(16'h3400);
    frame(16'h3600);
    u_host.noise(8'($urandom));
    frame(16'h3800);
    frame(16'hA11F);
    repeat (12) begin
      wa = 7'h1a + 7'($urandom_range(25));
      frame({1'b1, wa, 8'($urandom)});
    end
    for (int a = 'h1a; a <= 'h32; a += 2) frame({1'b0, 7'(a), 8'h00});
    // Event, mask and level interrupt
    axi_wr(4'h0, 32'h0000_0007);
    axi_wr(4'h4, 32'h0000_0002);
    wait_dr(300, hit);
    repeat (3) @(posedge ref_clk_i);
    chk("irq raised", 32'(irq), 1);
    axi_rd(4'h0, rd);
    chk("sample event", 32'(rd[1]), 1);
    axi_wr(4'h0, 32'h0000_0002);
    repeat (3) @(posedge ref_clk_i);
    chk("irq cleared", 32'(irq), 0);
    axi_wr(4'h4, 32'h0000_0000);
    // Pin as driven output, then as sample pacing input
    axi_wr(4'h8, 32'h0000_0006);
    repeat (3) @(posedge ref_clk_i);
    chk("pin drive", {30'h0, oe_n, pin_o}, 32'h1);
    axi_rd(4'hc, rd);
    chk("pin level", 32'(rd[17]), 1);
    axi_wr(4'h8, 32'h0000_0001);
    wait_dr(250, hit);
    chk("no pacing edge", 32'(hit), 0);
    pin_drv <= 1'b1;
    wait_dr(60, hit);
    chk("paced sample", 32'(hit), 1);
    pin_drv <= 1'b0;
    axi_wr(4'h8, 32'h0000_0000);
    // Flash backup and its counter
    axi_wr(4'h0, 32'h0000_0007);
    frame(16'hBE04);
    mem[0] = 16'h0001;
    chk("flash busy", 32'(busy), 1);
    while (busy !== 1'b0) @(posedge ref_clk_i);
    axi_rd(4'hc, rd);
    chk("flash count", rd[16:0], 17'h0_0001);
    axi_rd(4'h0, rd);
    chk("flash event", 32'(rd[2]), 1);
    // Unmapped offsets answer with a decode error and read as zero
    axi_wr(4'h2, 32'h0000_0007);
    axi_rd(4'h6, rd);
    chk("unmapped data", rd, 32'h0000_0000);
    frame(16'h0000);
    frame(16'h0000);
    // Doubling the period word halves the sample rate
    frame({1'b1, 7'h36, 8'h02});
    frame(16'h3600);
    frame(16'h0000);
    wait_dr(500, hit);
    wait_dr(300, hit);
    chk("slower rate", 32'(hit), 0);
    wait_dr(200, hit);
    chk("slower rate pulse", 32'(hit), 1);
    test_done();
  end
endmodule
`default_nettype wire
